// File: tb_vm_field_encoding_decoder.sv
`timescale 1ns/10ps
`default_nettype none
module tb_vm_field_encoding_decoder;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic vmEntry = 1'b0, exitLoad = 1'b0;
   logic [17:0] paddr = 18'h0;
   logic [31:0] pwdata = 32'h0;
   logic [2:0] exitSel = 3'h0;
   logic [63:0] exitData = 64'h0;
   wire logic pready, pslverr;
   wire logic [31:0] prdata;
   int error_cnt = 0, comparisons = 0;
   vfd_field_decoder DUT (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .vmEntry(vmEntry), .exitLoad(exitLoad),
      .exitSel(exitSel), .exitData(exitData)
   );
   initial begin
      forever #4 clk = ~clk;
   end
   // ****
   // helpers
   // ****
   function automatic logic [31:0] pat(input logic [14:0] id);
      return {1'b0, id, 1'b1, ~id};
   endfunction
   function automatic logic [17:0] fa(input logic [14:0] id);
      return {1'b0, id, 2'h0};
   endfunction
   function automatic logic [14:0] nid(input int i);
      return (i < 8) ? 15'h6000 + 15'(2 * i) : 15'h6800 + 15'(2 * (i - 8));
   endfunction
   task automatic ck(input string what, input logic [31:0] x, input logic [31:0] got);
      comparisons++;
      if (got !== x) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, x, got);
      end
   endtask
   // one apb transfer; on a read d is the expected data
   task automatic acc(input logic w, input logic [17:0] a, input logic [31:0] d,
         input logic xe);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      ck($sformatf("pready %h", a), 32'h1, {31'h0, pready});
      ck($sformatf("pslverr %h", a), {31'h0, xe}, {31'h0, pslverr});
      if (!w && !xe)
         ck($sformatf("prdata %h", a), d, prdata);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // upper word goes through the staging register first
   task automatic wr64(input logic [14:0] id, input logic [63:0] d, input logic xe);
      acc(1'b1, 18'h20000, d[63:32], 1'b0);
      acc(1'b1, fa(id), d[31:0], xe);
   endtask
   task automatic rd64(input logic [14:0] id, input logic [63:0] x);
      acc(1'b0, fa(id), x[31:0], 1'b0);
      acc(1'b0, 18'h20008, x[63:32], 1'b0);
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_g32;
      logic [14:0] id;
      for (int p = 0; p < 2; p++)
         for (int i = 0; i < 24; i++) begin
            id = 15'h4800 + 15'(2 * i);
            acc(p == 0, fa(id), pat(id), i == 22);
         end
      acc(1'b1, fa(15'h4c00), 32'h0000a5c3, 1'b0);
      acc(1'b0, fa(15'h4c02), 32'h0, 1'b1);
      acc(1'b0, fa(15'h4c00), 32'h0000a5c3, 1'b0);
      acc(1'b0, 18'h20008, 32'h0, 1'b0);
   endtask
   task automatic t_nat;
      logic [14:0] bad[9] = '{15'h6010, 15'h6814, 15'h6003, 15'h4801, 15'h4000,
         15'h4400, 15'h2800, 15'h0800, 15'h5800};
      for (int i = 0; i < 18; i++)
         wr64(nid(i), {pat(nid(i)), ~pat(nid(i))}, 1'b0);
      for (int i = 0; i < 18; i++)
         rd64(nid(i), {pat(nid(i)), ~pat(nid(i))});
      foreach (bad[i])
         acc(1'b0, fa(bad[i]), 32'h0, 1'b1);
      acc(1'b0, 18'h2000c, 32'h0, 1'b1);
      acc(1'b0, 18'h20004, 32'h00000051, 1'b0);
   endtask
   task automatic t_ro;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         exitLoad <= 1'b1;
         exitSel <= 3'(i);
         exitData <= {pat(15'(i)), ~pat(15'(i))};
         @(posedge clk);
         exitLoad <= 1'b0;
      end
      for (int i = 0; i < 6; i++) begin
         wr64(15'h6400 + 15'(2 * i), 64'h0, 1'b1);
         rd64(15'h6400 + 15'(2 * i), {pat(15'(i)), ~pat(15'(i))});
      end
      acc(1'b0, 18'h20004, 32'h000002be, 1'b0);
      acc(1'b1, 18'h20004, 32'h00000004, 1'b0);
      acc(1'b0, 18'h20004, 32'h000002ba, 1'b0);
   endtask
   task automatic t_ent;
      acc(1'b1, fa(15'h4810), 32'hffffffff, 1'b0);
      acc(1'b1, fa(15'h4812), 32'hffffffff, 1'b0);
      acc(1'b1, fa(15'h480e), 32'hffffffff, 1'b0);
      for (int i = 0; i < 5; i++)
         wr64(15'h6806 + 15'(2 * i), 64'hffffffffffffffff, 1'b0);
      @(posedge clk);
      vmEntry <= 1'b1;
      @(posedge clk);
      vmEntry <= 1'b0;
      acc(1'b0, fa(15'h4810), 32'h0000ffff, 1'b0);
      acc(1'b0, fa(15'h4812), 32'h0000ffff, 1'b0);
      acc(1'b0, fa(15'h480e), 32'hffffffff, 1'b0);
      for (int i = 0; i < 5; i++)
         rd64(15'h6806 + 15'(2 * i), {(i < 4) ? 32'h0 : 32'hffffffff, 32'hffffffff});
   endtask
   task automatic tally_and_finish;
      if (error_cnt == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd64(15'h6800, 64'h0);
      t_g32();
      t_nat();
      t_ro();
      t_ent();
      tally_and_finish();
   end
   // a hung handshake must not stall the run
   initial begin
      #(8 * 20000);
      error_cnt++;
      tally_and_finish();
   end
endmodule // tb_vm_field_encoding_decoder
`default_nettype wire

// File: vfd_field_decoder.v
`timescale 1ns/10ps
`default_nettype none
`include "vfd_regs.vh"

module vfd_field_decoder #(
   parameter NUM_TARGETS = 4,
   parameter HAS_PREEMPT = 1
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`VFD_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output wire pready,
   output reg [31:0] prdata,
   output reg pslverr,
   // core side events
   input wire vmEntry,
   input wire exitLoad,
   input wire [2:0] exitSel,
   input wire [63:0] exitData
);

   localparam NSLOT = 45 + NUM_TARGETS;

   // ***********************************
   // identifier decode
   // ***********************************
   // returns {supported, readOnly, slot}
   function [8:0] decodeId;
      input [`VFD_ID_W-1:0] id;
      reg [1:0] wcls;
      reg [1:0] area;
      reg [8:0] idx;
      reg ok;
      reg ro;
      reg [6:0] slot;
      begin
         wcls = id[`VFD_WCLS_MSB:`VFD_WCLS_LSB];
         area = id[`VFD_AREA_MSB:`VFD_AREA_LSB];
         idx = id[`VFD_IDX_MSB:`VFD_IDX_LSB];
         ok = 1'b0;
         ro = 1'b0;
         slot = 7'h00;
         if (wcls == `VFD_WCLS_32) begin
            case (area)
               `VFD_AREA_GST: begin
                  ok = (idx <= `VFD_G32_LAST_IDX) ||
                     ((idx == `VFD_PREEMPT_IDX) && (HAS_PREEMPT != 0));
                  slot = idx[6:0];
               end
               `VFD_AREA_HST: begin
                  ok = (idx == `VFD_H32_IDX);
                  slot = `VFD_SLOT_H32;
               end
               default: ok = 1'b0;
            endcase
         end else if (wcls == `VFD_WCLS_NAT) begin
            case (area)
               `VFD_AREA_CTL: begin
                  ok = (idx < (`VFD_NCTL_FIXED + NUM_TARGETS));
                  slot = `VFD_SLOT_NCTL + idx[6:0];
               end
               `VFD_AREA_RO: begin
                  ok = (idx < `VFD_NRO_COUNT);
                  ro = 1'b1;
                  slot = `VFD_SLOT_NRO + idx[6:0];
               end
               `VFD_AREA_GST: begin
                  ok = (idx < `VFD_NGST_COUNT);
                  slot = `VFD_SLOT_NGST + idx[6:0];
               end
               default: ok = 1'b0;
            endcase
         end
         // odd identifiers and a set reserved bit match nothing here
         if (id[`VFD_HIGH_BIT] || id[`VFD_RSV_BIT]) begin
            ok = 1'b0;
         end
         decodeId = {ok, ro, slot};
      end
   endfunction

   // ***********************************
   // bus phase decode
   // ***********************************
   wire setupPhase = psel & ~penable;
   wire accessPhase = psel & penable;
   wire isOwn = paddr[`VFD_OWN_BIT];
   wire [`VFD_ID_W-1:0] fieldId = paddr[`VFD_ID_W+1:2];
   wire [8:0] dec = decodeId(fieldId);
   wire decOk = dec[8] & ~isOwn;
   wire decRo = dec[7];
   wire [6:0] decSlot = dec[6:0];
   wire decNat = (fieldId[`VFD_WCLS_MSB:`VFD_WCLS_LSB] == `VFD_WCLS_NAT);
   wire ownHiWrite = (paddr == `VFD_HI_WRITE_OFS);
   wire ownStatus = (paddr == `VFD_STATUS_OFS);
   wire ownHiRead = (paddr == `VFD_HI_READ_OFS);
   wire ownHit = ownHiWrite | ownStatus | ownHiRead;
   // read-only fields refuse software writes
   wire fieldWrite = accessPhase & pwrite & decOk & ~decRo;
   wire roReject = accessPhase & pwrite & decOk & decRo;

   // zero wait states: read data and error are prepared in the setup cycle
   assign pready = 1'b1;

   // byte lanes for the low word
   wire [31:0] laneMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

   // ***********************************
   // field storage
   // ***********************************
   reg [31:0] hiStage;
   reg [31:0] hiCapture;
   reg rejectSticky;
   reg lastUnsup;
   reg lastRo;
   reg [`VFD_ID_W-1:0] lastId;
   wire [64*NSLOT-1:0] storeFlat;

   genvar s;
   generate
      for (s = 0; s < NSLOT; s = s + 1) begin : gSlot
         reg [63:0] value;
         reg [63:0] next_value;
         // slot number and read-only position as sized constants, no genvar slicing
         localparam [6:0] SIDX = s;
         localparam [6:0] RIDX = s - `VFD_SLOT_NRO;
         wire hit = fieldWrite && (decSlot == SIDX);
         wire exitHit = exitLoad && (s >= `VFD_SLOT_NRO) &&
            (s < `VFD_SLOT_NRO + `VFD_NRO_COUNT) &&
            ({4'h0, exitSel} == RIDX);
         always @* begin
            next_value = value;
            if (hit) begin
               // 32-bit fields keep the upper half at zero
               if (decNat) begin
                  next_value = {hiStage, (value[31:0] & ~laneMask) | (pwdata & laneMask)};
               end else begin
                  next_value = {32'h00000000, (value[31:0] & ~laneMask) | (pwdata & laneMask)};
               end
            end
            if (exitHit) begin
               next_value = exitData;
            end
            // entry clears after any same-cycle write so the guest never sees stale bits
            if (vmEntry && ((s == `VFD_SLOT_GDT_LIM) || (s == `VFD_SLOT_IDT_LIM))) begin
               next_value = next_value & `VFD_LIMIT_KEEP;
            end
            if (vmEntry && (s >= `VFD_SLOT_SEG_FIRST) && (s <= `VFD_SLOT_SEG_LAST)) begin
               next_value = next_value & `VFD_BASE_KEEP;
            end
         end
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               value <= 64'h0000000000000000;
            end else begin
               value <= next_value;
            end
         end
         assign storeFlat[64*s +: 64] = value;
      end
   endgenerate

   wire [63:0] selValue = storeFlat[64*decSlot +: 64];

   // ***********************************
   // own registers
   // ***********************************
   wire [31:0] statusWord = {16'h0000,
      lastId[`VFD_IDX_MSB:`VFD_IDX_LSB],
      lastId[`VFD_AREA_MSB:`VFD_AREA_LSB],
      lastId[`VFD_WCLS_MSB:`VFD_WCLS_LSB],
      rejectSticky, lastRo, lastUnsup};

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         hiStage <= 32'h00000000;
         hiCapture <= 32'h00000000;
         rejectSticky <= 1'b0;
         lastUnsup <= 1'b0;
         lastRo <= 1'b0;
         lastId <= 15'h0000;
      end else begin
         if (accessPhase && pwrite && ownHiWrite) begin
            hiStage <= pwdata;
         end
         // a natural-width read leaves its upper half for the next read
         if (accessPhase && ~pwrite && decOk && decNat) begin
            hiCapture <= selValue[63:32];
         end
         if (accessPhase && ~isOwn) begin
            lastUnsup <= ~dec[8];
            lastRo <= decRo;
            lastId <= fieldId;
         end
         // a reject in the clearing cycle wins over the clear
         if (roReject) begin
            rejectSticky <= 1'b1;
         end else if (accessPhase && pwrite && ownStatus && pwdata[`VFD_ST_REJECT]) begin
            rejectSticky <= 1'b0;
         end
      end
   end

   // ***********************************
   // read data and error
   // ***********************************
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (setupPhase) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
         if (isOwn) begin
            pslverr <= ~ownHit;
            if (~pwrite && ownHiWrite) begin
               prdata <= hiStage;
            end
            if (~pwrite && ownStatus) begin
               prdata <= statusWord;
            end
            if (~pwrite && ownHiRead) begin
               prdata <= hiCapture;
            end
         end else begin
            pslverr <= ~dec[8] | (pwrite & decRo);
            if (~pwrite && dec[8]) begin
               prdata <= selValue[31:0];
            end
         end
      end
   end

endmodule // vfd_field_decoder

`default_nettype wire

// File: vfd_field_decoder_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module vfd_field_decoder_checker #(
   parameter NUM_TARGETS = 4,
   parameter HAS_PREEMPT = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [17:0] paddr,
   input wire logic pslverr
);
   // ****
   // field window
   // ****
   wire logic [14:0] fid = paddr[16:2];
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // the answer to a setup cycle is judged one cycle later, in the access cycle
   sequence s_fld;
      psel && !penable && !paddr[17];
   endsequence
   a_odd_refused: assert property (s_fld ##0 fid[0] |=> pslverr)
      else $error("odd identifier accepted");
   a_class_refused: assert property (s_fld ##0 !fid[14] |=> pslverr)
      else $error("narrow class accepted");
   a_rsv_refused: assert property (s_fld ##0 fid[12] |=> pslverr)
      else $error("reserved bit accepted");
   a_area_refused: assert property (s_fld ##0 fid[14:11] == 4'h8 |=> pslverr)
      else $error("32-bit control or ro accepted");
   a_guest_ok: assert property (s_fld ##0 fid[14:10] == 5'h12 && !fid[0]
      && fid[9:1] <= 9'h15 |=> !pslverr)
      else $error("guest field refused");
   a_host_one: assert property (s_fld ##0 fid[14:10] == 5'h13
      |=> pslverr == ($past(fid) != 15'h4c00))
      else $error("host 32-bit decode wrong");
   a_timer_gate: assert property (s_fld ##0 fid == 15'h482e
      |=> pslverr == (HAS_PREEMPT == 0))
      else $error("timer field gating wrong");
   a_ro_write: assert property (s_fld ##0 pwrite && fid[14:10] == 5'h19 |=> pslverr)
      else $error("ro write accepted");
   a_ctl_ok: assert property (s_fld ##0 fid[14:10] == 5'h18 && !fid[0]
      && fid[9:1] < 4 + NUM_TARGETS |=> !pslverr)
      else $error("control field refused");
endmodule // vfd_field_decoder_checker
bind vfd_field_decoder vfd_field_decoder_checker #(
   .NUM_TARGETS(NUM_TARGETS),
   .HAS_PREEMPT(HAS_PREEMPT)
) u_chk (
   .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pslverr(pslverr)
);
`default_nettype wire

// File: vfd_regs.vh
// Function
// - An identifier with 3 in bits 14:13 is a natural-width field.
// - An identifier with 0 in bits 11:10 is a control field.
// - An identifier with 1 in bits 11:10 is a read-only data field that software cannot modify.
// - An identifier with 2 in bits 11:10 is a guest-state field.
// - An identifier with 3 in bits 11:10 is a host-state field.
// - Inside one width class and area the field is chosen by the index in bits 9:1.
// - Natural-width fields take full access only, so a valid identifier has bit 0 clear.
// - The 32-bit host area holds one field, the host fast-call selector, index 0, id 4c00.
// - Global and interrupt table limits are 32 bits; vm entry clears their upper 16 bits.
// - Guest extra, code, stack and data segment bases are 64 bits; entry clears the top 32.
// - Page-root targets beyond four take the identifiers right after the fourth one.
// - The preemption timer value, id 482e, exists only when the timer is supported.
// - An identifier with 2 in bits 14:13 is a 32-bit field, full access only, bit 0 clear.
`ifndef VFD_REGS_VH
`define VFD_REGS_VH

// ***********************************
// identifier layout
// ***********************************
`define VFD_ID_W 15
`define VFD_WCLS_MSB 14
`define VFD_WCLS_LSB 13
`define VFD_RSV_BIT 12
`define VFD_AREA_MSB 11
`define VFD_AREA_LSB 10
`define VFD_IDX_MSB 9
`define VFD_IDX_LSB 1
`define VFD_HIGH_BIT 0
`define VFD_WCLS_32 2'h2
`define VFD_WCLS_NAT 2'h3
`define VFD_AREA_CTL 2'h0
`define VFD_AREA_RO 2'h1
`define VFD_AREA_GST 2'h2
`define VFD_AREA_HST 2'h3
`define VFD_G32_LAST_IDX 9'h015
`define VFD_PREEMPT_IDX 9'h017
`define VFD_H32_IDX 9'h000
`define VFD_NRO_COUNT 9'h006
`define VFD_NGST_COUNT 9'h00a
`define VFD_NCTL_FIXED 9'h004

// ***********************************
// storage slots
// ***********************************
`define VFD_SLOT_H32 7'h18
`define VFD_SLOT_NRO 7'h19
`define VFD_SLOT_NGST 7'h1f
`define VFD_SLOT_NCTL 7'h29
`define VFD_SLOT_GDT_LIM 7'h08
`define VFD_SLOT_IDT_LIM 7'h09
`define VFD_SLOT_SEG_FIRST 7'h22
`define VFD_SLOT_SEG_LAST 7'h25

// ***********************************
// own registers and bus layout
// ***********************************
`define VFD_ADDR_W 18
`define VFD_OWN_BIT 17
`define VFD_HI_WRITE_OFS 18'h20000
`define VFD_STATUS_OFS 18'h20004
`define VFD_HI_READ_OFS 18'h20008
`define VFD_ST_UNSUP 0
`define VFD_ST_RO 1
`define VFD_ST_REJECT 2
`define VFD_ST_WCLS_LSB 3
`define VFD_ST_AREA_LSB 5
`define VFD_ST_IDX_LSB 7
`define VFD_LIMIT_KEEP 64'h000000000000ffff
`define VFD_BASE_KEEP 64'h00000000ffffffff

// ***********************************
// field identifiers (byte address is four times the identifier)
// ***********************************
`define VFD_VM_SEG0_LIMIT 15'h4800
`define VFD_VM_SEG1_LIMIT 15'h4802
`define VFD_VM_SEG2_LIMIT 15'h4804
`define VFD_VM_SEG3_LIMIT 15'h4806
`define VFD_VM_SEG4_LIMIT 15'h4808
`define VFD_VM_SEG5_LIMIT 15'h480a
`define VFD_VM_LOCAL_TABLE_LIMIT 15'h480c
`define VFD_VM_TASK_SEG_LIMIT 15'h480e
`define VFD_VM_GLOBAL_TABLE_LIMIT 15'h4810
`define VFD_VM_INTERRUPT_TABLE_LIMIT 15'h4812
`define VFD_VM_SEG0_RIGHTS 15'h4814
`define VFD_VM_SEG1_RIGHTS 15'h4816
`define VFD_VM_SEG2_RIGHTS 15'h4818
`define VFD_VM_SEG3_RIGHTS 15'h481a
`define VFD_VM_SEG4_RIGHTS 15'h481c
`define VFD_VM_SEG5_RIGHTS 15'h481e
`define VFD_VM_LOCAL_TABLE_RIGHTS 15'h4820
`define VFD_VM_TASK_SEG_RIGHTS 15'h4822
`define VFD_VM_INTERRUPTIBILITY 15'h4824
`define VFD_VM_ACTIVITY_STATE 15'h4826
`define VFD_VM_SMM_REBASE 15'h4828
`define VFD_VM_FAST_CALL_SELECTOR 15'h482a
`define VFD_VM_PREEMPT_TIMER_VALUE 15'h482e
`define VFD_HOST_FAST_CALL_SELECTOR 15'h4c00
`define VFD_SYS_CTL0_OWNER_MASK 15'h6000
`define VFD_SYS_CTL4_OWNER_MASK 15'h6002
`define VFD_SYS_CTL0_READ_SHADOW 15'h6004
`define VFD_SYS_CTL4_READ_SHADOW 15'h6006
`define VFD_PAGE_ROOT_TARGET_0 15'h6008
`define VFD_PAGE_ROOT_TARGET_1 15'h600a
`define VFD_PAGE_ROOT_TARGET_2 15'h600c
`define VFD_PAGE_ROOT_TARGET_3 15'h600e
`define VFD_EXIT_QUALIFICATION 15'h6400
`define VFD_IO_COUNT_REG_COPY 15'h6402
`define VFD_IO_SOURCE_INDEX_COPY 15'h6404
`define VFD_IO_DEST_INDEX_COPY 15'h6406
`define VFD_IO_INSTR_POINTER_COPY 15'h6408
`define VFD_VM_LINEAR_ADDR 15'h640a
`define VFD_VM_SYS_CTL0 15'h6800
`define VFD_VM_PAGE_ROOT 15'h6802
`define VFD_VM_SYS_CTL4 15'h6804
`define VFD_VM_SEG0_BASE 15'h6806
`define VFD_VM_SEG1_BASE 15'h6808
`define VFD_VM_SEG2_BASE 15'h680a
`define VFD_VM_SEG3_BASE 15'h680c
`define VFD_VM_SEG4_BASE 15'h680e
`define VFD_VM_SEG5_BASE 15'h6810
`define VFD_VM_LOCAL_TABLE_BASE 15'h6812

`endif
